// ---- hw/boot_memory_remap.sv ----
// boot memory remapper: decodes core code and data spaces for boot and
// normal mode, holds the remap and usb attach bits, owns the 8K ram
// and the internal direct ram; the boot rom macro sits outside.
// assumes the core issues at most one request per port per cycle and all
// core signals are on clk_i.
// Function
// - boot: rom at 0000-17FF and 8000-97FF
// - boot: 8K ram read/write at data 0000-1FFF
// - data FD80-FFFF goes to mapped regs always
// - normal: rom only at 8000-97FF
// - normal: 8K ram is code at 0000-1FFF
// - reset clears remap and attach bits
// - first fetch after reset reads rom 0000
// - firmware loads ram from eeprom or usb
// - firmware sets remap after load completes
// - attach only after remap has taken effect
// - 256-byte direct ram independent of remap
// - remap set by core, cleared by reset only
// - no writes to code space in normal mode
// - remap is bit 0 of config register
`timescale 1ns/1ns
module boot_memory_remap
  import remap_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  // instruction fetch port
  input  wire logic              fetch_req_i,
  input  wire logic [ADDR_W-1:0] fetch_addr_i,
  output logic                   fetch_valid_o,
  output logic      [DATA_W-1:0] fetch_data_o,
  // data space port
  input  wire logic              data_req_i,
  input  wire logic              data_we_i,
  input  wire logic [ADDR_W-1:0] data_addr_i,
  input  wire logic [DATA_W-1:0] data_wdata_i,
  output logic                   data_ready_o,
  output logic                   data_valid_o,
  output logic      [DATA_W-1:0] data_rdata_o,
  // internal direct ram port
  input  wire logic              internal_direct_ram_req_i,
  input  wire logic              internal_direct_ram_we_i,
  input  wire logic [7:0]        internal_direct_ram_addr_i,
  input  wire logic [DATA_W-1:0] internal_direct_ram_wdata_i,
  output logic                   internal_direct_ram_valid_o,
  output logic      [DATA_W-1:0] internal_direct_ram_rdata_o,
  // core configuration register
  input  wire logic              cfg_wr_i,
  input  wire logic [DATA_W-1:0] cfg_wdata_i,
  output logic      [DATA_W-1:0] cfg_rdata_o,
  // boot rom macro, combinational read
  output logic      [ROM_AW-1:0] rom_addr_o,
  input  wire logic [DATA_W-1:0] rom_data_i,
  // mapped control regs, buffers and i/o
  output logic                   mmr_req_o,
  output logic                   mmr_we_o,
  output logic      [ADDR_W-1:0] mmr_addr_o,
  output logic      [DATA_W-1:0] mmr_wdata_o,
  input  wire logic [DATA_W-1:0] mmr_rdata_i,
  // status
  output logic                   usb_attach_o,
  output logic                   boot_mode_o,
  output logic                   write_blocked_o
);

  // configuration and control state
  logic       remap;             // memory_remap_select
  logic       next_remap;
  logic [2:0] cfg_rw;            // config bits 7:5, plain storage
  logic [2:0] next_cfg_rw;
  logic [7:0] usb_ctl;           // usb_control_reg
  logic [7:0] next_usb_ctl;

  // fetch pipeline
  logic              fetch_valid;
  logic              next_fetch_valid;
  logic [DATA_W-1:0] fetch_data;
  logic [DATA_W-1:0] next_fetch_data;

  // data pipeline
  logic              data_valid;
  logic              next_data_valid;
  logic [DATA_W-1:0] data_rdata;
  logic [DATA_W-1:0] next_data_rdata;
  logic              mmr_pend;        // mapped access is in flight
  logic              next_mmr_pend;
  logic              mmr_we;
  logic              next_mmr_we;
  logic [ADDR_W-1:0] mmr_addr;
  logic [ADDR_W-1:0] next_mmr_addr;
  logic [DATA_W-1:0] mmr_wdata;
  logic [DATA_W-1:0] next_mmr_wdata;
  logic              wr_blocked;
  logic              next_wr_blocked;

  // internal direct ram pipeline
  logic              internal_direct_ram_valid;
  logic              next_internal_direct_ram_valid;
  logic [DATA_W-1:0] internal_direct_ram_rdata;
  logic [DATA_W-1:0] next_internal_direct_ram_rdata;

  // shared 8K ram port
  logic              ram_we;
  logic [RAM_AW-1:0] ram_addr;
  logic [DATA_W-1:0] ram_rdata;
  logic [DATA_W-1:0] idram_rdata;

  // accepted data request this cycle
  logic data_take;

  map_sel_if sel ();

  // decoder sees only the registered remap bit, so a write to it changes
  // the map for the next fetch, never the one in the same cycle
  always_comb begin
    sel.remap      = remap;
    sel.fetch_addr = fetch_addr_i;
    sel.data_addr  = data_addr_i;
  end

  space_decoder u_decoder (
    .sel (sel.decoder)
  );

  // one port serves both uses: in boot mode only the data side can reach
  // the ram and in normal mode only the fetch side, so no arbitration
  always_comb begin
    data_take = data_req_i && !mmr_pend;
    ram_addr  = remap ? fetch_addr_i[RAM_AW-1:0]
                      : data_addr_i[RAM_AW-1:0];
    // writes land only while the ram is data space
    ram_we    = data_take && data_we_i && sel.data_ram;
  end

  byte_ram #(
    .DEPTH (RAM_BYTES)
  ) u_code_ram (
    .clk_i   (clk_i),
    .we_i    (ram_we),
    .addr_i  (ram_addr),
    .wdata_i (data_wdata_i),
    .rdata_o (ram_rdata)
  );

  // direct ram has its own address space, untouched by remap
  byte_ram #(
    .DEPTH (INTERNAL_DIRECT_RAM_BYTES)
  ) u_direct_ram (
    .clk_i   (clk_i),
    .we_i    (internal_direct_ram_req_i && internal_direct_ram_we_i),
    .addr_i  (internal_direct_ram_addr_i),
    .wdata_i (internal_direct_ram_wdata_i),
    .rdata_o (idram_rdata)
  );

  // both rom windows are 8K aligned, so the low bits index the rom
  always_comb begin
    rom_addr_o = fetch_addr_i[ROM_AW-1:0];
  end

  // configuration and attach state, next values
  always_comb begin
    next_remap   = remap;
    next_cfg_rw  = cfg_rw;
    next_usb_ctl = usb_ctl;
    if (cfg_wr_i) begin
      // set-only: a zero written here leaves the bit alone
      next_remap  = remap | cfg_wdata_i[CFG_REMAP_POS];
      next_cfg_rw = cfg_wdata_i[7:CFG_RW_LSB];
    end
    if (data_take && data_we_i && sel.data_usb_control_reg) begin
      next_usb_ctl = data_wdata_i;
    end
  end

  // configuration and attach state, registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      // boot map and detached from the host
      remap   <= CFG_RESET[CFG_REMAP_POS];
      cfg_rw  <= CFG_RESET[7:CFG_RW_LSB];
      usb_ctl <= USB_CTL_RESET;
    end else begin
      remap   <= next_remap;
      cfg_rw  <= next_cfg_rw;
      usb_ctl <= next_usb_ctl;
    end
  end

  // config read: r/w bits, fixed revision, remap bit
  always_comb begin
    cfg_rdata_o = {cfg_rw, CFG_REVISION, remap};
  end

  // fetch path, next values; unmapped code space reads as a constant
  always_comb begin
    next_fetch_valid = fetch_req_i;
    next_fetch_data  = fetch_data;
    if (fetch_req_i) begin
      if (sel.fetch_rom) begin
        // after reset address 0000 lands here in boot mode
        next_fetch_data = rom_data_i;
      end else if (sel.fetch_ram) begin
        next_fetch_data = ram_rdata;
      end else begin
        next_fetch_data = UNMAPPED_READ;
      end
    end
  end

  // fetch path, registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fetch_valid <= 1'b0;
      fetch_data  <= UNMAPPED_READ;
    end else begin
      fetch_valid <= next_fetch_valid;
      fetch_data  <= next_fetch_data;
    end
  end

  // data path, next values; mapped accesses take one extra cycle
  // because the request to the peripherals is registered first
  always_comb begin
    next_data_valid = 1'b0;
    next_data_rdata = data_rdata;
    next_mmr_pend   = 1'b0;
    next_mmr_we     = 1'b0;
    next_mmr_addr   = mmr_addr;
    next_mmr_wdata  = mmr_wdata;
    next_wr_blocked = 1'b0;
    if (mmr_pend) begin
      // peripheral answers in the cycle it sees the request
      next_data_valid = 1'b1;
      next_data_rdata = mmr_we ? data_rdata : mmr_rdata_i;
    end else if (data_take) begin
      if (sel.data_mmr) begin
        // buffers, regs and i/o in either mode
        next_mmr_pend  = 1'b1;
        next_mmr_we    = data_we_i;
        next_mmr_addr  = data_addr_i;
        next_mmr_wdata = data_wdata_i;
      end else if (sel.data_usb_control_reg) begin
        next_data_valid = 1'b1;
        next_data_rdata = data_we_i ? data_rdata : usb_ctl;
      end else if (sel.data_ram) begin
        next_data_valid = 1'b1;
        next_data_rdata = data_we_i ? data_rdata : ram_rdata;
      end else begin
        // ram is code space now, or nothing is mapped: the write is
        // dropped and flagged so firmware bugs show up
        next_data_valid = 1'b1;
        next_data_rdata = data_we_i ? data_rdata : UNMAPPED_READ;
        next_wr_blocked = data_we_i;
      end
    end
  end

  // data path, registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      data_valid <= 1'b0;
      data_rdata <= UNMAPPED_READ;
      mmr_pend   <= 1'b0;
      mmr_we     <= 1'b0;
      mmr_addr   <= MMR_LO;
      mmr_wdata  <= UNMAPPED_READ;
      wr_blocked <= 1'b0;
    end else begin
      data_valid <= next_data_valid;
      data_rdata <= next_data_rdata;
      mmr_pend   <= next_mmr_pend;
      mmr_we     <= next_mmr_we;
      mmr_addr   <= next_mmr_addr;
      mmr_wdata  <= next_mmr_wdata;
      wr_blocked <= next_wr_blocked;
    end
  end

  // direct ram, next values
  always_comb begin
    next_internal_direct_ram_valid = internal_direct_ram_req_i;
    next_internal_direct_ram_rdata = internal_direct_ram_rdata;
    if (internal_direct_ram_req_i && !internal_direct_ram_we_i) begin
      next_internal_direct_ram_rdata = idram_rdata;
    end
  end

  // direct ram, registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      internal_direct_ram_valid <= 1'b0;
      internal_direct_ram_rdata <= UNMAPPED_READ;
    end else begin
      internal_direct_ram_valid <= next_internal_direct_ram_valid;
      internal_direct_ram_rdata <= next_internal_direct_ram_rdata;
    end
  end

  // outputs; attach is gated by remap so a premature write cannot put
  // the device on the bus while it still runs from the boot map
  always_comb begin
    fetch_valid_o   = fetch_valid;
    fetch_data_o    = fetch_data;
    data_ready_o    = !mmr_pend;
    data_valid_o    = data_valid;
    data_rdata_o    = data_rdata;
    internal_direct_ram_valid_o   = internal_direct_ram_valid;
    internal_direct_ram_rdata_o   = internal_direct_ram_rdata;
    mmr_req_o       = mmr_pend;
    mmr_we_o        = mmr_we;
    mmr_addr_o      = mmr_addr;
    mmr_wdata_o     = mmr_wdata;
    usb_attach_o    = usb_ctl[USB_ATTACH_POS] && remap;
    boot_mode_o     = !remap;
    write_blocked_o = wr_blocked;
  end

endmodule : boot_memory_remap

// ---- hw/byte_ram.sv ----
// single-port byte ram: synchronous write, combinational read
// assumes the caller registers the read data it presents outward
`timescale 1ns/1ns
module byte_ram #(
  parameter int DEPTH = 256,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [7:0]    wdata_i,
  output logic      [7:0]    rdata_o
);
  // storage; contents are undefined after power-up, as in real sram
  logic [7:0] mem [DEPTH];

  // read is combinational so the top gets single-cycle latency
  always_comb begin
    rdata_o = mem[addr_i];
  end

  // write on the clock edge only
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end
endmodule : byte_ram

// ---- hw/map_sel_if.sv ----
// decode bundle between the remapper top and its address decoder
// assumes both ends sit on the same core clock; contents are combinational
`timescale 1ns/1ns
interface map_sel_if;
  import remap_pkg::*;

  logic              remap;        // memory_remap_select, registered
  logic [ADDR_W-1:0] fetch_addr;   // code-space address
  logic [ADDR_W-1:0] data_addr;    // data-space address
  logic              fetch_rom;    // fetch hits the boot rom
  logic              fetch_ram;    // fetch hits the 8K ram
  logic              data_ram;     // data access hits the 8K ram
  logic              data_mmr;     // data access hits mapped_control_regs
  logic              data_usb_control_reg;  // data access hits usb_control_reg

  modport decoder (
    input  remap, fetch_addr, data_addr,
    output fetch_rom, fetch_ram, data_ram, data_mmr, data_usb_control_reg
  );
  modport user (
    output remap, fetch_addr, data_addr,
    input  fetch_rom, fetch_ram, data_ram, data_mmr, data_usb_control_reg
  );
endinterface : map_sel_if

// ---- hw/remap_pkg.sv ----
// constants, field positions and types of the boot/normal memory remapper
// assumes an 8-bit core with 16-bit code and data address spaces
package remap_pkg;

  localparam int ADDR_W = 16;             // code and data address width
  localparam int DATA_W = 8;              // byte-wide core

  // code space windows
  localparam logic [15:0] ROM_LO        = 16'h0000; // boot-mode rom window
  localparam logic [15:0] ROM_HI        = 16'h17FF;
  localparam logic [15:0] ROM_MIRROR_LO = 16'h8000; // rom copy, both modes
  localparam logic [15:0] ROM_MIRROR_HI = 16'h97FF;
  localparam logic [15:0] BOOT_FETCH    = 16'h0000; // first fetch after reset

  // 8K ram window, data space in boot mode, code space in normal mode
  localparam logic [15:0] RAM_LO = 16'h0000;
  localparam logic [15:0] RAM_HI = 16'h1FFF;

  // packet buffers, mapped control regs and i/o, data space in both modes
  localparam logic [15:0] MMR_LO = 16'hFD80;
  localparam logic [15:0] MMR_HI = 16'hFFFF;

  // usb control register inside the mapped control regs
  localparam logic [15:0] USB_CTL_ADDR   = 16'hFFFC;
  localparam int          USB_ATTACH_POS = 7;       // usb_attach_bit
  localparam logic [7:0]  USB_CTL_RESET  = 8'h00;

  // core configuration register fields
  localparam int         CFG_REMAP_POS = 0;         // memory_remap_select
  localparam int         CFG_REV_LSB   = 1;         // revision, read only
  localparam int         CFG_REV_MSB   = 4;
  localparam int         CFG_RW_LSB    = 5;         // plain r/w bits 7:5
  localparam logic [7:0] CFG_RESET     = 8'h00;
  localparam logic [3:0] CFG_REVISION  = 4'h1;      // arbitrary value

  // memory sizes in bytes
  localparam int ROM_BYTES   = 6144;
  localparam int RAM_BYTES   = 8192;
  localparam int INTERNAL_DIRECT_RAM_BYTES = 256;      // internal_direct_ram
  localparam int ROM_AW      = 13;       // rom address bits
  localparam int RAM_AW      = 13;

  localparam logic [7:0] UNMAPPED_READ = 8'h00; // value of empty space

  // source of a registered data-space read
  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_RAM,
    SRC_USB_CONTROL_REG
  } data_src_t;

endpackage : remap_pkg

// ---- hw/space_decoder.sv ----
// code and data address decoder for boot and normal memory maps
// assumes remap is already registered so a map switch is never seen mid-cycle
`timescale 1ns/1ns
module space_decoder
  import remap_pkg::*;
(
  map_sel_if.decoder sel
);
  logic fa_low;     // fetch address in bottom rom window
  logic fa_mirror;  // fetch address in rom copy window
  logic fa_ram;     // fetch address in ram window
  logic da_ram;     // data address in ram window

  // window compares, independent of mode
  always_comb begin
    fa_low    = sel.fetch_addr <= ROM_HI;
    fa_mirror = sel.fetch_addr >= ROM_MIRROR_LO
             && sel.fetch_addr <= ROM_MIRROR_HI;
    fa_ram    = sel.fetch_addr <= RAM_HI;
    da_ram    = sel.data_addr <= RAM_HI;
  end

  // mode-dependent selects
  always_comb begin
    // boot: bottom rom plus copy; normal: copy only
    sel.fetch_rom   = fa_mirror || (!sel.remap && fa_low);
    // ram becomes code only in normal mode
    sel.fetch_ram   = sel.remap && fa_ram;
    // ram is data only in boot mode
    sel.data_ram    = !sel.remap && da_ram;
    // mapped region is present in both modes
    sel.data_usb_control_reg = sel.data_addr == USB_CTL_ADDR;
    sel.data_mmr    = sel.data_addr >= MMR_LO && !sel.data_usb_control_reg;
  end
endmodule : space_decoder

// ---- test/boot_memory_remap_monitor.sv ----
// checker for the boot memory remapper, bound to its top module
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ns
module boot_memory_remap_monitor
  import remap_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              sys_rst_i,
  input wire logic              fetch_req_i,
  input wire logic [ADDR_W-1:0] fetch_addr_i,
  input wire logic              fetch_valid_o,
  input wire logic [DATA_W-1:0] fetch_data_o,
  input wire logic [DATA_W-1:0] rom_data_i,
  input wire logic              data_req_i,
  input wire logic              data_we_i,
  input wire logic [ADDR_W-1:0] data_addr_i,
  input wire logic              data_ready_o,
  input wire logic              data_valid_o,
  input wire logic              write_blocked_o,
  input wire logic              mmr_req_o,
  input wire logic [ADDR_W-1:0] mmr_addr_o,
  input wire logic              cfg_wr_i,
  input wire logic [DATA_W-1:0] cfg_wdata_i,
  input wire logic [DATA_W-1:0] cfg_rdata_o,
  input wire logic              usb_attach_o,
  input wire logic              boot_mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic take; // a data request accepted this cycle
  assign take = data_req_i && data_ready_o;
  chk_fetch_answer: assert property (fetch_req_i |=> fetch_valid_o)
    else $error("fetch not answered");
  chk_rom_boot: assert property (fetch_req_i && boot_mode_o &&
    fetch_addr_i <= ROM_HI |=> fetch_data_o == $past(rom_data_i))
    else $error("boot rom fetch wrong");
  chk_rom_mirror: assert property (fetch_req_i &&
    fetch_addr_i >= ROM_MIRROR_LO && fetch_addr_i <= ROM_MIRROR_HI
    |=> fetch_data_o == $past(rom_data_i))
    else $error("rom mirror fetch wrong");
  chk_mmr_route: assert property (take && data_addr_i >= MMR_LO &&
    data_addr_i != USB_CTL_ADDR |=> mmr_req_o && !data_ready_o &&
    mmr_addr_o == $past(data_addr_i))
    else $error("mmr access not routed");
  chk_code_wr_block: assert property (take && data_we_i &&
    !boot_mode_o && data_addr_i <= RAM_HI |=> write_blocked_o &&
    data_valid_o) else $error("code space write not blocked");
  chk_remap_set: assert property (cfg_wr_i &&
    cfg_wdata_i[CFG_REMAP_POS] |=> !boot_mode_o)
    else $error("remap bit not set");
  chk_remap_sticky: assert property (!boot_mode_o |=> !boot_mode_o)
    else $error("remap bit cleared");
  chk_attach_gate: assert property (usb_attach_o |-> !boot_mode_o)
    else $error("attached before remap");
  chk_boot_mode_bit: assert property (boot_mode_o ==
    !cfg_rdata_o[CFG_REMAP_POS]) else $error("remap bit misplaced");
  chk_reset_clear: assert property (disable iff (1'b0) sys_rst_i
    |=> boot_mode_o && !usb_attach_o) else $error("reset left map");
  cov_remap: cover property ($fell(boot_mode_o));
  cov_mmr: cover property (mmr_req_o);
  cov_block: cover property (write_blocked_o);
endmodule : boot_memory_remap_monitor

bind boot_memory_remap boot_memory_remap_monitor u_boot_memory_remap_monitor (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .fetch_req_i(fetch_req_i),
  .fetch_addr_i(fetch_addr_i), .fetch_valid_o(fetch_valid_o),
  .fetch_data_o(fetch_data_o), .rom_data_i(rom_data_i),
  .data_req_i(data_req_i), .data_we_i(data_we_i),
  .data_addr_i(data_addr_i), .data_ready_o(data_ready_o),
  .data_valid_o(data_valid_o), .write_blocked_o(write_blocked_o),
  .mmr_req_o(mmr_req_o), .mmr_addr_o(mmr_addr_o), .cfg_wr_i(cfg_wr_i),
  .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
  .usb_attach_o(usb_attach_o), .boot_mode_o(boot_mode_o)
);

// ---- test/boot_rom_mmr_model.sv ----
// boot rom macro and mapped control region stand-in for the remapper
// assumes a combinational rom and a one-cycle mmr request pulse
`timescale 1ns/1ns
module boot_rom_mmr_model
  import remap_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic [ROM_AW-1:0] rom_addr_i,
  output logic      [DATA_W-1:0] rom_data_o,
  input  wire logic              mmr_req_i,
  input  wire logic              mmr_we_i,
  input  wire logic [ADDR_W-1:0] mmr_addr_i,
  input  wire logic [DATA_W-1:0] mmr_wdata_i,
  output logic      [DATA_W-1:0] mmr_rdata_o,
  output logic      [DATA_W-1:0] last_wdata_o
);
  logic [DATA_W-1:0] held = 8'hA5; // last byte answered
  // rom bytes follow the address so every location is known
  assign rom_data_o = rom_addr_i[7:0] ^ 8'h5A;
  // outside a request the lines show the inverse, never a stale match
  assign mmr_rdata_o = mmr_req_i ? (mmr_addr_i[7:0] ^ 8'h3C) : ~held;
  // remember answers and written bytes
  always_ff @(posedge clk_i) begin
    if (mmr_req_i) held <= mmr_rdata_o;
    if (mmr_req_i && mmr_we_i) last_wdata_o <= mmr_wdata_i;
  end
endmodule : boot_rom_mmr_model

// ---- test/tb_top.sv ----
// self-checking bench for the boot memory remapper
// assumes the rom/mmr stand-in model answers the far side
`timescale 1ns/1ns
module tb_top;
  import remap_pkg::*;
  logic              clk_i, sys_rst_i, fetch_req_i, fetch_valid_o;
  logic              data_req_i, data_we_i, data_ready_o, data_valid_o;
  logic              internal_direct_ram_req_i, internal_direct_ram_we_i, internal_direct_ram_valid_o, cfg_wr_i;
  logic              mmr_req_o, mmr_we_o, usb_attach_o, boot_mode_o;
  logic              write_blocked_o, blk;
  logic [ADDR_W-1:0] fetch_addr_i, data_addr_i, mmr_addr_o;
  logic [DATA_W-1:0] fetch_data_o, data_wdata_i, data_rdata_o, internal_direct_ram_addr_i;
  logic [DATA_W-1:0] internal_direct_ram_wdata_i, internal_direct_ram_rdata_o, cfg_wdata_i, cfg_rdata_o;
  logic [DATA_W-1:0] rom_data_i, mmr_wdata_o, mmr_rdata_i, last_wdata;
  logic [ROM_AW-1:0] rom_addr_o;
  logic [8:0]        got;          // {valid, byte} of the last answer
  int                num_errors, cmp_count, cycles;
  logic [15:0]       la [3] = '{16'h0000, 16'h0010, 16'h1FFF}; // ram spots
  logic [7:0]        ld [3] = '{8'h11, 8'hA7, 8'h3E};

  boot_memory_remap u_boot_memory_remap (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .fetch_req_i(fetch_req_i),
    .fetch_addr_i(fetch_addr_i), .fetch_valid_o(fetch_valid_o),
    .fetch_data_o(fetch_data_o), .data_req_i(data_req_i),
    .data_we_i(data_we_i), .data_addr_i(data_addr_i),
    .data_wdata_i(data_wdata_i), .data_ready_o(data_ready_o),
    .data_valid_o(data_valid_o), .data_rdata_o(data_rdata_o),
    .internal_direct_ram_req_i(internal_direct_ram_req_i), .internal_direct_ram_we_i(internal_direct_ram_we_i),
    .internal_direct_ram_addr_i(internal_direct_ram_addr_i), .internal_direct_ram_wdata_i(internal_direct_ram_wdata_i),
    .internal_direct_ram_valid_o(internal_direct_ram_valid_o), .internal_direct_ram_rdata_o(internal_direct_ram_rdata_o),
    .cfg_wr_i(cfg_wr_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(cfg_rdata_o), .rom_addr_o(rom_addr_o),
    .rom_data_i(rom_data_i), .mmr_req_o(mmr_req_o), .mmr_we_o(mmr_we_o),
    .mmr_addr_o(mmr_addr_o), .mmr_wdata_o(mmr_wdata_o),
    .mmr_rdata_i(mmr_rdata_i), .usb_attach_o(usb_attach_o),
    .boot_mode_o(boot_mode_o), .write_blocked_o(write_blocked_o));
  boot_rom_mmr_model u_boot_rom_mmr_model (
    .clk_i(clk_i), .rom_addr_i(rom_addr_o), .rom_data_o(rom_data_i),
    .mmr_req_i(mmr_req_o), .mmr_we_i(mmr_we_o), .mmr_addr_i(mmr_addr_o),
    .mmr_wdata_i(mmr_wdata_o), .mmr_rdata_o(mmr_rdata_i),
    .last_wdata_o(last_wdata));

  // 125 MHz core clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // hang guard, far above the fewer than a hundred cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [8:0] romb(input logic [15:0] a);
    return {1'b1, a[7:0] ^ 8'h5A};
  endfunction : romb
  task automatic reset_dut();
    sys_rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
  endtask : reset_dut
  // one fetch; a spare edge passes so requests never retoggle at once
  task automatic fetch(input logic [15:0] a);
    fetch_addr_i = a;
    fetch_req_i  = 1'b1;
    @(posedge clk_i) #1;
    fetch_req_i  = 1'b0;
    got = {fetch_valid_o, fetch_data_o};
    @(posedge clk_i) #1;
  endtask : fetch
  // one data access, waiting a bounded time for the answer
  task automatic dacc(input logic we, input logic [15:0] a,
                      input logic [7:0] wd);
    {data_we_i, data_addr_i, data_wdata_i} = {we, a, wd};
    data_req_i = 1'b1;
    @(posedge clk_i) #1;
    data_req_i = 1'b0;
    for (int i = 0; i < 3 && data_valid_o !== 1'b1; i++) @(posedge clk_i) #1;
    got = {data_valid_o, data_rdata_o};
    blk = write_blocked_o;
    @(posedge clk_i) #1;
  endtask : dacc
  task automatic iacc(input logic we, input logic [7:0] a,
                      input logic [7:0] wd);
    {internal_direct_ram_we_i, internal_direct_ram_addr_i, internal_direct_ram_wdata_i} = {we, a, wd};
    internal_direct_ram_req_i = 1'b1;
    @(posedge clk_i) #1;
    internal_direct_ram_req_i = 1'b0;
    got = {internal_direct_ram_valid_o, internal_direct_ram_rdata_o};
    @(posedge clk_i) #1;
  endtask : iacc
  task automatic cfg(input logic [7:0] wd);
    cfg_wdata_i = wd;
    cfg_wr_i    = 1'b1;
    @(posedge clk_i) #1;
    cfg_wr_i    = 1'b0;
    @(posedge clk_i) #1;
  endtask : cfg

  // reset state and the boot-mode code map
  task automatic t_boot();
    check({1'b0, cfg_rdata_o}, 9'h002);
    check({7'h0, boot_mode_o, usb_attach_o}, 9'h002);
    fetch(BOOT_FETCH);
    check(got, 9'h15A);
    foreach (la[i]) begin
      fetch(16'h17FF ^ (la[i] & 16'h8000) | (i == 2 ? 16'h8000 : 16'h0));
      check(got, romb(fetch_addr_i));
    end
    fetch(16'h1800);
    check(got, 9'h100);
    $display("boot map test done");
  endtask : t_boot
  // firmware copies code into data-space ram, plus direct ram use
  task automatic t_load();
    foreach (la[i]) begin
      dacc(1'b1, la[i], ld[i]);
      check({7'h0, got[8], blk}, 9'h002);
    end
    foreach (la[i]) begin
      dacc(1'b0, la[i], 8'h00);
      check(got, {1'b1, ld[i]});
    end
    iacc(1'b1, 8'h20, 8'h5C);
    iacc(1'b0, 8'h20, 8'h00);
    check(got, 9'h15C);
    $display("ram load test done");
  endtask : t_load
  // mapped regions, and an attach request before the remap
  task automatic t_mmr();
    dacc(1'b0, 16'hFE00, 8'h00);
    check(got, 9'h13C);
    dacc(1'b1, MMR_LO, 8'h99);
    check({1'b0, last_wdata}, 9'h099);
    dacc(1'b1, USB_CTL_ADDR, 8'h80);
    check({8'h0, usb_attach_o}, 9'h000);
    dacc(1'b0, USB_CTL_ADDR, 8'h00);
    check(got, 9'h180);
    $display("mapped region test done");
  endtask : t_mmr
  // normal mode: ram as code, write lock, sticky bit, attach allowed
  task automatic t_remap();
    cfg(8'hE1);
    check({1'b0, cfg_rdata_o}, 9'h0E3);
    check({7'h0, boot_mode_o, usb_attach_o}, 9'h001);
    foreach (la[i]) begin
      fetch(la[i]);
      check(got, {1'b1, ld[i]});
    end
    fetch(ROM_MIRROR_LO);
    check(got, romb(ROM_MIRROR_LO));
    cfg(8'h00);
    check({1'b0, cfg_rdata_o}, 9'h003);
    dacc(1'b1, 16'h0010, 8'hFF);
    check({7'h0, got[8], blk}, 9'h003);
    fetch(16'h0010);
    check(got, 9'h1A7);
    dacc(1'b0, 16'h0010, 8'h00);
    check(got, 9'h100);
    iacc(1'b0, 8'h20, 8'h00);
    check(got, 9'h15C);
    dacc(1'b0, 16'hFE00, 8'h00);
    check(got, 9'h13C);
    $display("normal map test done");
  endtask : t_remap
  // second reset, then a remap write in the cycle of a fetch
  task automatic t_switch();
    reset_dut();
    check({7'h0, boot_mode_o, usb_attach_o}, 9'h002);
    dacc(1'b1, 16'h0000, 8'h6B);
    cfg_wdata_i = 8'h01;
    cfg_wr_i    = 1'b1;
    fetch(16'h0000);
    cfg_wr_i    = 1'b0;
    check(got, 9'h15A);
    fetch(16'h0000);
    check(got, 9'h16B);
    $display("map switch test done");
  endtask : t_switch

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  // main sequence
  initial begin
    {sys_rst_i, fetch_req_i, data_req_i, data_we_i} = 4'h8;
    {internal_direct_ram_req_i, internal_direct_ram_we_i, cfg_wr_i} = 3'h0;
    {fetch_addr_i, data_addr_i} = 32'h0;
    {data_wdata_i, internal_direct_ram_addr_i, internal_direct_ram_wdata_i, cfg_wdata_i} = 32'h0;
    reset_dut();
    t_boot();
    t_load();
    t_mmr();
    t_remap();
    t_switch();
    finish_test();
  end
endmodule : tb_top
